// *** inc/seq_pkg.sv ***
// shared constants and types for the dual output startup sequencer
package seq_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SLAVE_DELAY_US   = 400;
  localparam int unsigned SLAVE_DELAY_CYC  = SLAVE_DELAY_US * CLK_MHZ;
  localparam int unsigned SOFT_START_US    = 2100;
  localparam int unsigned SOFT_START_CYC   = SOFT_START_US * CLK_MHZ;
  localparam int unsigned REF_STEPS        = 256;
  localparam int unsigned STEP_CYC         = SOFT_START_CYC / REF_STEPS;
  localparam int unsigned OSC_DIV          = 16;
  localparam int unsigned CNT_W            = 20;
  localparam int unsigned REF_W            = 8;
  localparam logic [REF_W-1:0] REF_FULL    = 8'hff;
  localparam logic [REF_W-1:0] REF_ZERO    = 8'h00;

  // ------------------------------------------------------------------
  // strap codes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ORDER_OUT1_FIRST = 2'b00,
    ORDER_FREE       = 2'b01,
    ORDER_OUT2_FIRST = 2'b11
  } order_t;

  // sequencer state along power-up
  typedef enum logic [1:0] {
    ST_LOCKOUT  = 2'b00,
    ST_SHUTDOWN = 2'b01,
    ST_CHARGE   = 2'b11,
    ST_RUN      = 2'b10
  } seq_state_t;

  // per-channel controls
  typedef struct packed {
    logic run;
    logic soft_start;
  } chan_ctl_t;

endpackage

// *** logic/sync2.sv ***
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // sync2

// *** logic/soft_start_ramp.sv ***
// digital soft start reference ramp for one channel
`timescale 1ns/1ps
module soft_start_ramp
  import seq_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // control
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] step_cyc,
  // reference
  output logic      [REF_W-1:0] ref_level,
  output logic                  ramp_done
);
  logic [CNT_W-1:0] tick;

  // ------------------------------------------------------------------
  // ramp from zero to full, then hold
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick      <= '0;
      ref_level <= REF_ZERO;
    end else if (!run) begin
      tick      <= '0;
      ref_level <= REF_ZERO;
    end else if (ref_level != REF_FULL) begin
      if (tick + 1'b1 >= step_cyc) begin
        tick      <= '0;
        ref_level <= ref_level + 1'b1;
      end else begin
        tick <= tick + 1'b1;
      end
    end
  end

  assign ramp_done = (ref_level == REF_FULL);
endmodule // soft_start_ramp

// *** logic/startup_sequencer.sv ***
// startup and enable sequencing for a two-channel regulator
`timescale 1ns/1ps
module startup_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned SLAVE_DELAY = SLAVE_DELAY_CYC,
  parameter int unsigned STEP        = STEP_CYC
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // analog comparators
  input  wire logic             undervoltage_lockout,
  input  wire logic             bootstrap_supply_ready,
  input  wire logic             output1_enable_n,
  input  wire logic             output2_enable_n,
  input  wire logic             output1_in_regulation,
  input  wire logic             output2_in_regulation,
  // three-state strap: sensed high and sensed low
  input  wire logic             order_strap_high,
  input  wire logic             order_strap_low,
  // controls
  output logic                  bootstrap_regulator_on,
  output logic                  output1_switch_enable,
  output logic                  output2_switch_enable,
  output logic                  output1_phase,
  output logic                  output2_phase,
  output logic      [REF_W-1:0] output1_ref,
  output logic      [REF_W-1:0] output2_ref,
  output order_t                startup_order_select,
  output seq_state_t            seq_state
);
  logic [7:0] raw;
  logic [7:0] syn;
  logic       lockout, supply_ok, want1, want2, reg1, reg2, s_hi, s_lo;
  logic       strap_taken;
  seq_state_t next_state;
  chan_ctl_t  ch1, ch2;
  logic       slave_go;
  logic [CNT_W-1:0] dly;
  logic [3:0] osc;
  logic       osc_half;
  logic       r1_done, r2_done;
  logic       joint_start;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------------
  // synchronise pins
  // ------------------------------------------------------------------
  // lockout and enables pass inverted: a cleared flop reads as safe
  assign raw = {~undervoltage_lockout, bootstrap_supply_ready,
                ~output1_enable_n, ~output2_enable_n,
                output1_in_regulation, output2_in_regulation,
                order_strap_high, order_strap_low};

  sync2 #(.W(8)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .d        (raw),
    .q        (syn)
  );

  assign lockout   = ~syn[7];
  assign supply_ok = syn[6];
  assign want1     = syn[5];
  assign want2     = syn[4];
  assign reg1  = syn[3];
  assign reg2  = syn[2];
  assign s_hi  = syn[1];
  assign s_lo  = syn[0];

  // ------------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_taken          <= 1'b0;
      startup_order_select <= ORDER_FREE;
    end else if (lockout) begin
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      if (s_hi)
        startup_order_select <= ORDER_OUT2_FIRST;
      else if (s_lo)
        startup_order_select <= ORDER_OUT1_FIRST;
      else
        startup_order_select <= ORDER_FREE;
    end
  end

  // ------------------------------------------------------------------
  // power-up state
  // ------------------------------------------------------------------
  always_comb begin
    next_state = seq_state;
    case (seq_state)
      ST_LOCKOUT:  if (!lockout && strap_taken) next_state = ST_SHUTDOWN;
      ST_SHUTDOWN: if (want1 || want2) next_state = ST_CHARGE;
      ST_CHARGE: begin
        if (!(want1 || want2)) next_state = ST_SHUTDOWN;
        else if (supply_ok) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!(want1 || want2)) next_state = ST_SHUTDOWN;
        else if (!supply_ok) next_state = ST_CHARGE;
      end
      default: next_state = ST_LOCKOUT;
    endcase
    if (lockout) next_state = ST_LOCKOUT;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) seq_state <= ST_LOCKOUT;
    else       seq_state <= next_state;
  end

  assign bootstrap_regulator_on = (seq_state == ST_CHARGE) ||
                                  (seq_state == ST_RUN);

  // ------------------------------------------------------------------
  // channel run decisions
  // ------------------------------------------------------------------
  always_comb begin
    ch1 = '0;
    ch2 = '0;
    if (seq_state == ST_RUN) begin
      case (startup_order_select)
        ORDER_OUT2_FIRST: begin
          ch2.run = want2;
          ch1.run = want2 && slave_go;
        end
        ORDER_OUT1_FIRST: begin
          ch1.run = want1;
          ch2.run = want1 && slave_go;
        end
        default: begin
          ch1.run = want1;
          ch2.run = want2;
        end
      endcase
    end
    ch1.soft_start = ch1.run && !r1_done;
    ch2.soft_start = ch2.run && !r2_done;
  end

  // ------------------------------------------------------------------
  // slave delay after master regulation
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dly      <= '0;
      slave_go <= 1'b0;
    end else if (seq_state != ST_RUN ||
                 (startup_order_select == ORDER_OUT2_FIRST && !want2) ||
                 (startup_order_select == ORDER_OUT1_FIRST && !want1)) begin
      dly      <= '0;
      slave_go <= 1'b0;
    end else if (!slave_go &&
                 ((startup_order_select == ORDER_OUT2_FIRST && reg2) ||
                  (startup_order_select == ORDER_OUT1_FIRST && reg1))) begin
      if (dly + 1'b1 >= CNT_W'(SLAVE_DELAY)) slave_go <= 1'b1;
      else dly <= dly + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // soft start ramps, one per channel run; joint_start only feeds the ramp check
  // ------------------------------------------------------------------
  assign joint_start = (startup_order_select == ORDER_FREE) &&
                       ch1.run && ch2.run;

  soft_start_ramp u_ramp1 (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .run       (ch1.run),
    .step_cyc  (CNT_W'(STEP)),
    .ref_level (output1_ref),
    .ramp_done (r1_done)
  );

  soft_start_ramp u_ramp2 (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .run       (ch2.run),
    .step_cyc  (CNT_W'(STEP)),
    .ref_level (output2_ref),
    .ramp_done (r2_done)
  );

  // ------------------------------------------------------------------
  // shared oscillator, two phases
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc      <= 4'h0;
      osc_half <= 1'b0;
    end else if (seq_state == ST_LOCKOUT) begin
      osc      <= 4'h0;
      osc_half <= 1'b0;
    end else begin
      osc <= osc + 4'h1;
      if (osc == 4'(OSC_DIV - 1)) osc_half <= ~osc_half;
    end
  end

  // registered switch enables and phase strobes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      output1_switch_enable <= 1'b0;
      output2_switch_enable <= 1'b0;
      output1_phase         <= 1'b0;
      output2_phase         <= 1'b0;
    end else begin
      output1_switch_enable <= ch1.run && !lockout;
      output2_switch_enable <= ch2.run && !lockout;
      output1_phase <= ch1.run && !osc_half && (osc == 4'h0);
      output2_phase <= ch2.run && osc_half && (osc == 4'h0);
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence s_master_lost;
    seq_state == ST_RUN && startup_order_select == ORDER_OUT2_FIRST && !want2;
  endsequence

  a_lockout_all_off: assert property (
    lockout |=> !output1_switch_enable && !output2_switch_enable)
    else $error("switch on during lockout");
  a_reg_shutdown: assert property (
    (seq_state != ST_LOCKOUT && !lockout && !want1 && !want2) |=>
      !bootstrap_regulator_on)
    else $error("regulator on in shutdown");
  a_reg_enable: assert property (
    (seq_state == ST_SHUTDOWN && !lockout && want1) |=>
      bootstrap_regulator_on)
    else $error("regulator not on after enable");
  a_run_needs_ready: assert property (
    $rose(output1_switch_enable) |-> $past(supply_ok, 2))
    else $error("modulator on before supply ready");
  a_out2first_stop: assert property (
    s_master_lost |=> !output1_switch_enable && !output2_switch_enable)
    else $error("both outputs not stopped");
  a_out1first_stop: assert property (
    (seq_state == ST_RUN && startup_order_select == ORDER_OUT1_FIRST &&
     !want1) |=> !output1_switch_enable && !output2_switch_enable)
    else $error("both outputs not stopped on enable 1");
  a_out1first_hold: assert property (
    (startup_order_select == ORDER_OUT1_FIRST && !reg1 && !slave_go) |=>
      !output2_switch_enable)
    else $error("slave output 2 started early");
  a_out2first_hold: assert property (
    (startup_order_select == ORDER_OUT2_FIRST && !reg2 && !slave_go) |=>
      !output1_switch_enable)
    else $error("slave output 1 started early");
  a_phase_apart: assert property (
    !(output1_phase && output2_phase))
    else $error("phases coincide");
  a_independent_ch: assert property (
    (seq_state == ST_RUN && next_state == ST_RUN &&
     startup_order_select == ORDER_FREE) |=>
      output2_switch_enable == $past(want2))
    else $error("channel 2 not under its own enable");
  a_joint_ramp: assert property (
    (joint_start && $past(!ch1.run && !ch2.run)) |=>
      output1_ref == output2_ref)
    else $error("ratiometric ramps diverge");
  a_ramp_holds: assert property (
    (ch1.run && !ch1.soft_start) |=> output1_ref == REF_FULL)
    else $error("reference left full level");
endmodule // startup_sequencer

// *** verif/supply_model.sv ***
// supply rail and regulation model at the sequencer's far side
`timescale 1ns/1ps
module supply_model
  import seq_pkg::*;
#(
  parameter int unsigned READY_DLY = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // from the sequencer
  input  wire logic             bootstrap_regulator_on,
  input  wire logic             output1_switch_enable,
  input  wire logic             output2_switch_enable,
  input  wire logic [REF_W-1:0] output1_ref,
  input  wire logic [REF_W-1:0] output2_ref,
  // slow rail when set
  input  wire logic             hold_ready,
  // comparators
  output logic                  bootstrap_supply_ready,
  output logic                  output1_in_regulation,
  output logic                  output2_in_regulation
);
  logic [7:0] charge;

  // ------------------------------------------------------------------
  // bootstrap rail charges only while its regulator runs
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      charge <= 8'h00;
    end else if (!bootstrap_regulator_on) begin
      charge <= 8'h00;
    end else if (!hold_ready && charge < 8'(READY_DLY)) begin
      charge <= charge + 8'h01;
    end
  end
  assign bootstrap_supply_ready = !hold_ready && charge == 8'(READY_DLY);

  // ------------------------------------------------------------------
  // output regulates once its ramp is full, drops when switching stops
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      output1_in_regulation <= 1'b0;
      output2_in_regulation <= 1'b0;
    end else begin
      output1_in_regulation <= output1_switch_enable && output1_ref == REF_FULL;
      output2_in_regulation <= output2_switch_enable && output2_ref == REF_FULL;
    end
  end
endmodule // supply_model

// *** verif/dual_output_startup_sequencer_test.sv ***
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
module dual_output_startup_sequencer_test
  import seq_pkg::*;
;
  localparam int unsigned SD = 20;
  typedef struct packed {
    logic sh, sl, e1, e2, s1, s2, rg;
    logic [1:0] ord;
  } row_t;
  // strap high/low, enables, expected switches, regulator, order
  row_t rows [8] = '{9'b0100_111_00, 9'b1000_111_11, 9'b0000_111_01,
    9'b0001_101_01, 9'b0010_011_01, 9'b0011_000_01, 9'b0110_001_00,
    9'b1001_001_11};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic undervoltage_lockout = 1'b1;
  logic output1_enable_n = 1'b1;
  logic output2_enable_n = 1'b1;
  logic order_strap_high = 1'b0;
  logic order_strap_low = 1'b0;
  logic hold_ready = 1'b0;
  logic bootstrap_supply_ready, output1_in_regulation, output2_in_regulation;
  logic bootstrap_regulator_on, output1_switch_enable, output2_switch_enable;
  logic output1_phase, output2_phase;
  logic [REF_W-1:0] output1_ref, output2_ref;
  order_t startup_order_select;
  seq_state_t seq_state;
  int err_count = 0;
  int checked = 0;

  always #2.5 core_clk = ~core_clk;

  startup_sequencer #(.SLAVE_DELAY(SD), .STEP(2)) dut_u (
    .core_clk(core_clk), .rstn(rstn),
    .undervoltage_lockout(undervoltage_lockout),
    .bootstrap_supply_ready(bootstrap_supply_ready),
    .output1_enable_n(output1_enable_n), .output2_enable_n(output2_enable_n),
    .output1_in_regulation(output1_in_regulation),
    .output2_in_regulation(output2_in_regulation),
    .order_strap_high(order_strap_high), .order_strap_low(order_strap_low),
    .bootstrap_regulator_on(bootstrap_regulator_on),
    .output1_switch_enable(output1_switch_enable),
    .output2_switch_enable(output2_switch_enable),
    .output1_phase(output1_phase), .output2_phase(output2_phase),
    .output1_ref(output1_ref), .output2_ref(output2_ref),
    .startup_order_select(startup_order_select), .seq_state(seq_state));

  supply_model rail_u (
    .core_clk(core_clk), .rstn(rstn),
    .bootstrap_regulator_on(bootstrap_regulator_on),
    .output1_switch_enable(output1_switch_enable),
    .output2_switch_enable(output2_switch_enable),
    .output1_ref(output1_ref), .output2_ref(output2_ref),
    .hold_ready(hold_ready),
    .bootstrap_supply_ready(bootstrap_supply_ready),
    .output1_in_regulation(output1_in_regulation),
    .output2_in_regulation(output2_in_regulation));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic start(input logic sh, sl, e1, e2);
    @(posedge core_clk);
    rstn <= 1'b0;
    undervoltage_lockout <= 1'b1;
    order_strap_high <= sh;
    order_strap_low <= sl;
    output1_enable_n <= e1;
    output2_enable_n <= e2;
    tick(12);
    @(negedge core_clk);
    chk("reset state", 8'(ST_LOCKOUT), 8'(seq_state));
    chk("reset order", 8'(ORDER_FREE), 8'(startup_order_select));
    chk("reset outputs", 8'h00, {5'h00, bootstrap_regulator_on,
        output1_switch_enable, output2_switch_enable});
    @(posedge core_clk);
    rstn <= 1'b1;
    tick(2);
    undervoltage_lockout <= 1'b0;
  endtask

  // master enable released after both run stops both
  task automatic seq_case(input logic hi);
    int n = 0;
    start(hi, ~hi, 1'b0, 1'b0);
    while ((hi ? output2_in_regulation : output1_in_regulation) !== 1'b1
           && n < 2000) begin
      @(negedge core_clk);
      chk("slave waits", 8'h00, 8'(hi ? output1_switch_enable
                                      : output2_switch_enable));
      n++;
    end
    n = 0;
    while ((hi ? output1_switch_enable : output2_switch_enable) !== 1'b1
           && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk("slave delay", 8'h01, 8'(n >= SD && n <= SD + 8));
    @(posedge core_clk);
    if (hi) begin
      output2_enable_n <= 1'b1;
    end else begin
      output1_enable_n <= 1'b1;
    end
    tick(1);
    @(negedge core_clk);
    chk("sync lag", 8'h03, 8'({output1_switch_enable,
                               output2_switch_enable}));
    tick(4);
    @(negedge core_clk);
    chk("both stop", 8'h00, 8'({output1_switch_enable,
                                output2_switch_enable}));
    $display("sequential test done");
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    int p1;
    int p2;
    int last;
    foreach (rows[i]) begin
      start(rows[i].sh, rows[i].sl, rows[i].e1, rows[i].e2);
      tick(1500);
      @(negedge core_clk);
      chk("switch 1", 8'(rows[i].s1), 8'(output1_switch_enable));
      chk("switch 2", 8'(rows[i].s2), 8'(output2_switch_enable));
      chk("regulator", 8'(rows[i].rg), 8'(bootstrap_regulator_on));
      chk("order", 8'(rows[i].ord), 8'(startup_order_select));
      chk("ref 1", rows[i].s1 ? REF_FULL : REF_ZERO, output1_ref);
      $display("row %0d done", i);
    end
    seq_case(1'b1);
    seq_case(1'b0);
    // ratiometric start, phase alternation, lockout, strap recapture
    p1 = 0;
    p2 = 0;
    last = 0;
    start(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (1500) begin
      @(negedge core_clk);
      chk("refs equal", output1_ref, output2_ref);
      chk("phases apart", 8'h00, 8'(output1_phase & output2_phase));
      if (output1_phase === 1'b1) begin
        chk("phase 1 turn", 8'h01, 8'(last != 1));
        last = 1;
        p1++;
      end
      if (output2_phase === 1'b1) begin
        chk("phase 2 turn", 8'h01, 8'(last != 2));
        last = 2;
        p2++;
      end
    end
    chk("phase count", 8'h01, 8'(p1 > 10 && p2 > 10));
    @(posedge core_clk);
    order_strap_low <= 1'b1;
    tick(10);
    @(negedge core_clk);
    chk("order kept", 8'(ORDER_FREE), 8'(startup_order_select));
    @(posedge core_clk);
    undervoltage_lockout <= 1'b1;
    tick(5);
    @(negedge core_clk);
    chk("lockout off", 8'h00, {5'h00, bootstrap_regulator_on,
        output1_switch_enable, output2_switch_enable});
    chk("lockout state", 8'(ST_LOCKOUT), 8'(seq_state));
    @(posedge core_clk);
    undervoltage_lockout <= 1'b0;
    tick(10);
    @(negedge core_clk);
    chk("order retaken", 8'(ORDER_OUT1_FIRST), 8'(startup_order_select));
    $display("lockout test done");
    // slow bootstrap rail keeps modulators off
    @(posedge core_clk);
    hold_ready <= 1'b1;
    start(1'b0, 1'b0, 1'b0, 1'b0);
    tick(200);
    @(negedge core_clk);
    chk("charge state", 8'(ST_CHARGE), 8'(seq_state));
    chk("regulator on", 8'h01, 8'(bootstrap_regulator_on));
    chk("no switching", 8'h00, 8'(output1_switch_enable));
    @(posedge core_clk);
    hold_ready <= 1'b0;
    tick(30);
    @(negedge core_clk);
    chk("switching", 8'h01, 8'(output1_switch_enable));
    $display("ready test done");
    conclude();
  end

  initial begin
    #200000;
    err_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule // dual_output_startup_sequencer_test
